/* File: design/ifch_regs.svh */
// register offsets, field positions, fixed values and reset values of the ide function header
`ifndef IFCH_REGS_SVH
`define IFCH_REGS_SVH

`define IFCH_OFF_COMMAND 8'h04
`define IFCH_OFF_CLASS 8'h08
`define IFCH_OFF_MISC 8'h0c
`define IFCH_OFF_CMD_WIN 8'h10
`define IFCH_OFF_CTL_WIN 8'h14

`define IFCH_OFF_PROG_IF 8'h09
`define IFCH_OFF_SUBTYPE 8'h0a
`define IFCH_OFF_CATEGORY 8'h0b
`define IFCH_OFF_HOLD_TIMER 8'h0d
`define IFCH_OFF_LAYOUT 8'h0e

`define IFCH_POS_IO_ENABLE 0
`define IFCH_POS_PRI_NATIVE 8

`define IFCH_VAL_SUBTYPE 8'h01
`define IFCH_VAL_CATEGORY 8'h01
`define IFCH_VAL_HOLD_TIMER 8'h00
`define IFCH_VAL_LAYOUT 8'h80
`define IFCH_VAL_PROG_IF_FIXED 8'h8a

`define IFCH_RST_WINDOW 32'h00000001
`define IFCH_RST_PROG_IF 8'h8a

`define IFCH_CMD_WIN_LOW 3
`define IFCH_CTL_WIN_LOW 2
`define IFCH_LEGACY_CMD_BASE 32'h000001f0
`define IFCH_LEGACY_CMD_MASK 32'hfffffff8
`define IFCH_LEGACY_CTL_ADDR 32'h000003f6

`endif

/* File: design/ifch_pkg.sv */
// types and shared helpers of the ide function header
`default_nettype none
package ifch_pkg;
    typedef enum logic {IFCH_LEGACY, IFCH_NATIVE} ifch_mode_t;
    typedef logic [31:0] ifch_word_t;

    // byte lane merge of a configuration write
    function automatic ifch_word_t ifch_merge(input ifch_word_t old_v, input ifch_word_t new_v,
                                              input logic [3:0] be);
        ifch_word_t r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

/* File: design/ifch_window.sv */
// one io window base register with hardwired low bits and address match
`include "ifch_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ifch_window import ifch_pkg::*; #(
    parameter int LOW = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [3:0] wr_be,
    input wire ifch_word_t wr_data,
    input wire ifch_word_t io_addr,
    output ifch_word_t win_value,
    output logic match
);
    localparam ifch_word_t HI_MASK = 32'hffffffff << LOW;

    ifch_word_t base_q;
    ifch_word_t base_d;

    always_comb begin
        base_d = base_q;
        if (wr_en) begin
            // low bits never store, io indicator forced
            base_d = (ifch_merge(base_q, wr_data, wr_be) & HI_MASK) | `IFCH_RST_WINDOW;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            base_q <= `IFCH_RST_WINDOW;
        end else begin
            base_q <= base_d;
        end
    end

    assign win_value = base_q;
    assign match = (io_addr & HI_MASK) == (base_q & HI_MASK);
endmodule
`default_nettype wire

/* File: design/ifch_top.sv */
// ide function configuration header with primary channel io decode
// How it works
// - legacy mode decodes command block 1F0h-1F7h and control at 3F6h.
// - native mode decodes at addresses held in both window registers.
// - device subtype code reads 01h, writes ignored.
// - device category code reads 01h, writes ignored.
// - bus hold timer is hardwired to 00h.
// - configuration layout type reads 80h, reporting multi-function device.
// - command window bits 31-3 writable, base of 8-byte io range.
// - command window bit 2 always reads 0.
// - both windows: bit 1 reads 0, bit 0 reads 1, writes ignored.
// - control window bits 31-2 writable, base of 4-byte io range.
// - both windows reset to 00000001h.
// - window contents used for decode only in native mode.
// - io ranges answered only while the io enable bit is set.
`include "ifch_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ifch_top import ifch_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire ifch_word_t cfg_wdata,
    output logic cfg_ack_q,
    output ifch_word_t cfg_rdata_q,
    input wire logic io_valid,
    input wire ifch_word_t io_addr,
    output logic io_cmd_hit_q,
    output logic io_ctl_hit_q
);
    logic [7:0] cfg_dw;
    logic cfg_wr;
    logic io_en_q;
    logic io_en_d;
    ifch_mode_t pri_mode_q;
    ifch_mode_t pri_mode_d;
    logic cfg_ack_d;
    ifch_word_t cfg_rdata_d;
    logic io_cmd_hit_d;
    logic io_ctl_hit_d;
    ifch_word_t cmd_win;
    ifch_word_t ctl_win;
    logic cmd_match;
    logic ctl_match;
    logic legacy_cmd;
    logic legacy_ctl;
    ifch_word_t cmd_word;
    ifch_word_t class_word;
    ifch_word_t cmd_merged;
    ifch_word_t class_merged;

    // host bridge turns cf8/cfc cycles into this port
    assign cfg_dw = {cfg_addr[7:2], 2'b00};
    assign cfg_wr = cfg_req && cfg_we;

    ifch_window #(
        .LOW(`IFCH_CMD_WIN_LOW)
    ) u_cmd_win (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(cfg_wr && (cfg_dw == `IFCH_OFF_CMD_WIN)),
        .wr_be(cfg_be),
        .wr_data(cfg_wdata),
        .io_addr(io_addr),
        .win_value(cmd_win),
        .match(cmd_match)
    );

    ifch_window #(
        .LOW(`IFCH_CTL_WIN_LOW)
    ) u_ctl_win (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(cfg_wr && (cfg_dw == `IFCH_OFF_CTL_WIN)),
        .wr_be(cfg_be),
        .wr_data(cfg_wdata),
        .io_addr(io_addr),
        .win_value(ctl_win),
        .match(ctl_match)
    );

    // writable control bits: io enable and primary mode select
    always_comb begin
        cmd_word = {31'h0, io_en_q};
        class_word = {`IFCH_VAL_CATEGORY, `IFCH_VAL_SUBTYPE,
                      `IFCH_VAL_PROG_IF_FIXED | {7'h0, pri_mode_q == IFCH_NATIVE}, 8'h00};
        cmd_merged = ifch_merge(cmd_word, cfg_wdata, cfg_be);
        class_merged = ifch_merge(class_word, cfg_wdata, cfg_be);
        io_en_d = io_en_q;
        pri_mode_d = pri_mode_q;
        if (cfg_wr && cfg_dw == `IFCH_OFF_COMMAND) begin
            io_en_d = cmd_merged[`IFCH_POS_IO_ENABLE];
        end
        if (cfg_wr && cfg_dw == `IFCH_OFF_CLASS) begin
            pri_mode_d = class_merged[`IFCH_POS_PRI_NATIVE] ? IFCH_NATIVE : IFCH_LEGACY;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_en_q <= 1'b0;
            pri_mode_q <= IFCH_LEGACY;
        end else begin
            io_en_q <= io_en_d;
            pri_mode_q <= pri_mode_d;
        end
    end

    // configuration read mux, one cycle answer
    always_comb begin
        cfg_ack_d = cfg_req;
        cfg_rdata_d = 32'h0;
        if (cfg_req && !cfg_we) begin
            case (cfg_dw)
                `IFCH_OFF_COMMAND: begin
                    cfg_rdata_d = cmd_word;
                end
                `IFCH_OFF_CLASS: begin
                    cfg_rdata_d = class_word;
                end
                `IFCH_OFF_MISC: begin
                    cfg_rdata_d = {8'h00, `IFCH_VAL_LAYOUT, `IFCH_VAL_HOLD_TIMER, 8'h00};
                end
                // low bits come hardwired from the window
                `IFCH_OFF_CMD_WIN: begin
                    cfg_rdata_d = cmd_win;
                end
                `IFCH_OFF_CTL_WIN: begin
                    cfg_rdata_d = ctl_win;
                end
                default: begin
                    cfg_rdata_d = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_ack_q <= 1'b0;
            cfg_rdata_q <= 32'h0;
        end else begin
            cfg_ack_q <= cfg_ack_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // io address decode
    assign legacy_cmd = (io_addr & `IFCH_LEGACY_CMD_MASK) == `IFCH_LEGACY_CMD_BASE;
    assign legacy_ctl = io_addr == `IFCH_LEGACY_CTL_ADDR;

    always_comb begin
        io_cmd_hit_d = 1'b0;
        io_ctl_hit_d = 1'b0;
        // nothing claimed while io is disabled
        if (io_valid && io_en_q) begin
            case (pri_mode_q)
                IFCH_NATIVE: begin
                    io_cmd_hit_d = cmd_match;
                    io_ctl_hit_d = ctl_match;
                end
                IFCH_LEGACY: begin
                    io_cmd_hit_d = legacy_cmd;
                    io_ctl_hit_d = legacy_ctl;
                end
                default: begin
                    io_cmd_hit_d = 1'b0;
                    io_ctl_hit_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_cmd_hit_q <= 1'b0;
            io_ctl_hit_q <= 1'b0;
        end else begin
            io_cmd_hit_q <= io_cmd_hit_d;
            io_ctl_hit_q <= io_ctl_hit_d;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_cfg_read(logic [7:0] off);
        cfg_req && !cfg_we && cfg_dw == off;
    endsequence

    sequence s_cfg_full_write(logic [7:0] off);
        cfg_req && cfg_we && cfg_be == 4'hf && cfg_dw == off;
    endsequence

    sequence s_io_cycle(logic mode_native);
        io_valid && io_en_q && (pri_mode_q == IFCH_NATIVE) == mode_native;
    endsequence

    a_legacy_decode: assert property (
        s_io_cycle(1'b0) |=> io_cmd_hit_q == $past(legacy_cmd) && io_ctl_hit_q == $past(legacy_ctl))
        else $error("legacy decode wrong");

    a_native_decode: assert property (
        s_io_cycle(1'b1) |=> io_cmd_hit_q == $past(cmd_match) && io_ctl_hit_q == $past(ctl_match))
        else $error("native decode wrong");

    a_native_base_match: assert property (
        s_io_cycle(1'b1) ##0 ((io_addr ^ cmd_win) & 32'hfffffff8) == 32'h0 |=> io_cmd_hit_q)
        else $error("native command cycle not claimed");

    a_subtype_code: assert property (
        s_cfg_read(`IFCH_OFF_CLASS) |=> cfg_ack_q && cfg_rdata_q[23:16] == 8'h01)
        else $error("subtype code not 01h");

    a_category_code: assert property (
        s_cfg_read(`IFCH_OFF_CLASS) |=> cfg_rdata_q[31:24] == 8'h01)
        else $error("category code not 01h");

    a_hold_timer_zero: assert property (
        s_cfg_read(`IFCH_OFF_MISC) |=> cfg_rdata_q[15:8] == 8'h00)
        else $error("hold timer not zero");

    a_layout_type: assert property (
        s_cfg_read(`IFCH_OFF_MISC) |=> cfg_rdata_q[23:16] == 8'h80)
        else $error("layout type not 80h");

    a_cmd_win_write: assert property (
        s_cfg_full_write(`IFCH_OFF_CMD_WIN) |=> (cmd_win & 32'hfffffff8) == ($past(cfg_wdata) & 32'hfffffff8))
        else $error("command window base not stored");

    a_cmd_win_bit2: assert property (
        s_cfg_read(`IFCH_OFF_CMD_WIN) |=> cfg_rdata_q[2] == 1'b0)
        else $error("command window bit 2 not zero");

    a_win_low_bits: assert property (
        cfg_wr |=> cmd_win[1:0] == 2'b01 && ctl_win[1:0] == 2'b01)
        else $error("window low bits not 01");

    a_ctl_win_write: assert property (
        s_cfg_full_write(`IFCH_OFF_CTL_WIN) |=> (ctl_win & 32'hfffffffc) == ($past(cfg_wdata) & 32'hfffffffc))
        else $error("control window base not stored");

    a_win_reset_value: assert property (
        $fell(sys_rst) |-> cmd_win == 32'h00000001 && ctl_win == 32'h00000001 && !io_en_q)
        else $error("window reset value wrong");

    a_legacy_ignores_win: assert property (
        s_io_cycle(1'b0) ##0 (!legacy_cmd && cmd_match) |=> !io_cmd_hit_q)
        else $error("window used in legacy mode");

    a_io_disabled: assert property (
        !io_en_q |=> !io_cmd_hit_q && !io_ctl_hit_q)
        else $error("io claimed while disabled");

    a_ctl_win_low: assert property (
        s_cfg_read(`IFCH_OFF_CTL_WIN) |=> cfg_rdata_q[1:0] == 2'b01)
        else $error("control window low bits not 01");

    a_native_ctl_match: assert property (
        s_io_cycle(1'b1) ##0 ((io_addr ^ ctl_win) & 32'hfffffffc) == 32'h0 |=> io_ctl_hit_q)
        else $error("native control cycle not claimed");

    a_legacy_cmd_range: assert property (
        s_io_cycle(1'b0) ##0 io_addr[31:3] == 29'h0000003e |=> io_cmd_hit_q)
        else $error("legacy command block not claimed");

    a_legacy_ctl_port: assert property (
        s_io_cycle(1'b0) ##0 io_addr == 32'h000003f6 |=> io_ctl_hit_q)
        else $error("legacy control port not claimed");

    a_native_no_fixed: assert property (
        s_io_cycle(1'b1) ##0 (legacy_cmd && !cmd_match) |=> !io_cmd_hit_q)
        else $error("fixed ports claimed in native mode");

    a_legacy_ctl_ignored: assert property (
        s_io_cycle(1'b0) ##0 (!legacy_ctl && ctl_match) |=> !io_ctl_hit_q)
        else $error("control window used in legacy mode");

    a_cfg_answer: assert property (
        cfg_req |=> cfg_ack_q)
        else $error("configuration access not answered");

    a_class_write_kept: assert property (
        s_cfg_full_write(`IFCH_OFF_CLASS) ##2 s_cfg_read(`IFCH_OFF_CLASS) |=> cfg_rdata_q[31:16] == 16'h0101)
        else $error("class codes changed by a write");

    a_misc_write_kept: assert property (
        s_cfg_full_write(`IFCH_OFF_MISC) ##2 s_cfg_read(`IFCH_OFF_MISC) |=> cfg_rdata_q[23:8] == 16'h8000)
        else $error("hold timer or layout changed by a write");
endmodule
`default_nettype wire

/* File: verification/ifch_host_model.sv */
// host bridge model issuing configuration accesses to the ide function header
`timescale 1ns/1ns
`default_nettype none
module ifch_host_model import ifch_pkg::*; (
    input wire logic clk,
    output logic cfg_req,
    output logic cfg_we,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output ifch_word_t cfg_wdata,
    input wire logic cfg_ack_q,
    input wire ifch_word_t cfg_rdata_q
);
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
    end

    task automatic xfer(input logic we, input logic [7:0] addr, input logic [3:0] be, input ifch_word_t wd,
                        output logic ack, output ifch_word_t rd);
        @(negedge clk);
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = wd;
        @(negedge clk);
        ack = cfg_ack_q;
        rd = cfg_rdata_q;
        cfg_req = 1'b0;
        // released lines show no stale value
        cfg_we = ~we;
        cfg_addr = ~addr;
        cfg_be = ~be;
        cfg_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

/* File: verification/ifch_top_tb_top.sv */
// self-checking testbench of the ide function header
`timescale 1ns/1ns
`default_nettype none
module ifch_top_tb_top import ifch_pkg::*;;
    logic clk;
    logic sys_rst;
    logic cfg_req;
    logic cfg_we;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    ifch_word_t cfg_wdata;
    logic cfg_ack_q;
    ifch_word_t cfg_rdata_q;
    logic io_valid;
    ifch_word_t io_addr;
    logic io_cmd_hit_q;
    logic io_ctl_hit_q;
    int error_cnt = 0;
    int n_checks = 0;
    ifch_word_t leg_a[9] = '{32'h1ef, 32'h1f0, 32'h1f7, 32'h1f8, 32'h3f5, 32'h3f6, 32'h3f7, 32'hffffff00,
                             32'hfffffffd};
    ifch_word_t nat_a[9] = '{32'hc100, 32'hc107, 32'hc108, 32'h1f0, 32'hc204, 32'hc207, 32'hc208, 32'h3f6,
                             32'hc0ff};

    ifch_host_model i_ifch_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q));
    ifch_top i_ifch_top (.clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
        .io_valid(io_valid), .io_addr(io_addr), .io_cmd_hit_q(io_cmd_hit_q), .io_ctl_hit_q(io_ctl_hit_q));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_word(input string what, input ifch_word_t exp, input ifch_word_t got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] addr, input ifch_word_t exp);
        logic ack;
        ifch_word_t d;
        i_ifch_host_model.xfer(1'b0, addr, 4'hf, 32'h00000000, ack, d);
        chk_flag("cfg_ack_q", 1'b1, ack);
        chk_word("cfg_rdata_q", exp, d);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [3:0] be, input ifch_word_t wd);
        logic ack;
        ifch_word_t d;
        i_ifch_host_model.xfer(1'b1, addr, be, wd, ack, d);
        chk_flag("cfg_ack_q", 1'b1, ack);
        chk_word("cfg_rdata_q", 32'h00000000, d);
    endtask

    task automatic io_chk(input ifch_word_t a, input logic ec, input logic el);
        @(negedge clk);
        io_valid = 1'b1;
        io_addr = a;
        @(negedge clk);
        io_valid = 1'b0;
        io_addr = ~a;
        chk_flag("io_cmd_hit_q", ec, io_cmd_hit_q);
        chk_flag("io_ctl_hit_q", el, io_ctl_hit_q);
    endtask

    task automatic t_reset_values();
        rd(8'h08, 32'h01018a00);
        rd(8'h0c, 32'h00800000);
        rd(8'h10, 32'h00000001);
        rd(8'h14, 32'h00000001);
        rd(8'h04, 32'h00000000);
        rd(8'h40, 32'h00000000);
    endtask

    task automatic t_readonly();
        wr(8'h0c, 4'hf, 32'hffffffff);
        rd(8'h0c, 32'h00800000);
        wr(8'h08, 4'hf, 32'hffffffff);
        rd(8'h08, 32'h01018b00);
        wr(8'h08, 4'hf, 32'h00000000);
        rd(8'h08, 32'h01018a00);
    endtask

    task automatic t_windows();
        wr(8'h10, 4'hf, 32'hffffffff);
        rd(8'h10, 32'hfffffff9);
        wr(8'h14, 4'hf, 32'hffffffff);
        rd(8'h14, 32'hfffffffd);
        wr(8'h10, 4'h1, 32'h00000000);
        rd(8'h10, 32'hffffff01);
    endtask

    task automatic t_legacy();
        io_chk(32'h1f0, 1'b0, 1'b0);
        wr(8'h04, 4'hf, 32'h00000001);
        foreach (leg_a[i]) begin
            io_chk(leg_a[i], leg_a[i] >= 32'h1f0 && leg_a[i] <= 32'h1f7, leg_a[i] == 32'h3f6);
        end
    endtask

    task automatic t_native();
        wr(8'h08, 4'hf, 32'h00000100);
        wr(8'h10, 4'hf, 32'h0000c106);
        wr(8'h14, 4'hf, 32'h0000c206);
        rd(8'h10, 32'h0000c101);
        rd(8'h14, 32'h0000c205);
        foreach (nat_a[i]) begin
            io_chk(nat_a[i], nat_a[i][31:3] == 29'h00001820, nat_a[i][31:2] == 30'h00003081);
        end
        wr(8'h04, 4'hf, 32'h00000000);
        io_chk(32'hc100, 1'b0, 1'b0);
        io_chk(32'hc204, 1'b0, 1'b0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        io_valid = 1'b0;
        io_addr = 32'h00000000;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_reset_values();
        t_readonly();
        t_windows();
        t_legacy();
        t_native();
        test_done();
    end

    // watchdog well beyond the roughly one hundred cycles of the tests
    initial begin
        #50000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
